// ### hdl/port_ctrl_pkg.sv
package port_ctrl_pkg;

    // Register indices; each register owns one aligned 32-bit word
    localparam logic [9:0]  IDX_ASSIGN  = 10'h00A;
    localparam logic [9:0]  IDX_PULL    = 10'h00C;
    localparam logic [9:0]  IDX_DRIVE   = 10'h00D;
    localparam logic [11:0] ADDR_ASSIGN = {IDX_ASSIGN, 2'b00};
    localparam logic [11:0] ADDR_PULL   = {IDX_PULL, 2'b00};
    localparam logic [11:0] ADDR_DRIVE  = {IDX_DRIVE, 2'b00};
    localparam logic [11:0] ADDR_MODE   = 12'h010;

    // Bit positions in the assignment register
    localparam int BIT_NO_BUS_EN = 7;
    localparam int BIT_TEST_OUT  = 6;
    localparam int BIT_PIPE_OUT  = 5;
    localparam int BIT_NO_ECLK   = 4;
    localparam int BIT_STROBE_EN = 3;
    localparam int BIT_RW_EN     = 2;
    localparam int BIT_CAL_EN    = 1;
    localparam int BIT_INV_E_SEL = 0;
    // Control-port pull enable in the pull register
    localparam int BIT_PULL_CTRL = 4;

    // Pin positions on the control port
    localparam int PIN_BUS_EN = 7;
    localparam int PIN_PIPE_H = 6;
    localparam int PIN_PIPE_L = 5;
    localparam int PIN_ECLK   = 4;
    localparam int PIN_STROBE = 3;
    localparam int PIN_RW     = 2;

    // Operating modes
    typedef enum logic [2:0] {
        MODE_NORM_SINGLE   = 3'h0,
        MODE_NORM_EXP_NAR  = 3'h1,
        MODE_NORM_EXP_WIDE = 3'h3,
        MODE_SPEC_SINGLE   = 3'h2,
        MODE_SPEC_EXP_NAR  = 3'h6,
        MODE_SPEC_EXP_WIDE = 3'h7,
        MODE_PERIPHERAL    = 3'h5,
        MODE_SPEC_TEST     = 3'h4
    } op_mode_e;

    // Reset values: assignment register per mode, then pull and drive registers
    localparam logic [7:0] RST_NORM_EXP = 8'h00;
    localparam logic [7:0] RST_SPEC_EXP = 8'h2C;
    localparam logic [7:0] RST_PERIPH   = 8'hD0;
    localparam logic [7:0] RST_NORM_SC  = 8'h90;
    localparam logic [7:0] RST_SPEC_SC  = 8'h2E;
    localparam logic [7:0] RST_PULL     = 8'h00;
    localparam logic [7:0] RST_DRIVE    = 8'h00;

    // Implemented bits of the drive register
    localparam logic [7:0] DRIVE_MASK   = 8'hF3;
    // Control-port pins that can take a pull-up
    localparam logic [7:0] PULL_PINS    = 8'h8F;
    // Pins that can never be driven (interrupt inputs)
    localparam logic [7:0] INPUT_ONLY   = 8'h03;

    // Write permission classes
    typedef enum logic [1:0] {
        WR_ONCE_NORM = 2'h0,
        WR_NEVER_N   = 2'h1,
        WR_ECLK      = 2'h2,
        WR_ANY       = 2'h3
    } wr_class_e;

endpackage

// ### hdl/apb_if.sv
`timescale 1ns/10ps
`default_nettype none
interface apb_if;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic        wr_fire;
    logic        rd_fire;
    logic [31:0] rdata;
    logic        hit;

    modport slave (
        input  psel, penable, pwrite, paddr, pwdata, pstrb, rdata, hit,
        output wr_fire, rd_fire
    );
    modport core (
        input  wr_fire, rd_fire, paddr, pwdata, pstrb,
        output rdata, hit
    );
endinterface
`default_nettype wire

// ### hdl/apb_slave.sv
`timescale 1ns/10ps
`default_nettype none
module apb_slave (
    apb_if.slave      bus,
    output var logic  pready,
    output var logic  pslverr,
    output var logic [31:0] prdata
);
    // Zero wait state: the access phase is the answer cycle
    always_comb begin
        pready     = 1'b1;
        bus.wr_fire = bus.psel && bus.penable && bus.pwrite;
        bus.rd_fire = bus.psel && bus.penable && !bus.pwrite;
        pslverr    = bus.psel && bus.penable && !bus.hit;
        prdata     = (bus.rd_fire && bus.hit) ? bus.rdata : 32'h0000_0000;
    end
endmodule
`default_nettype wire

// ### hdl/port_e_pin_assignment.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: normal single-chip reset leaves all pins GPIO
// R2: normal expanded reset enables bus enable, E
// R3: special expanded reset enables bus control set
// R4: special single-chip also enables calibration
// R5: alternate function overrides pin direction bit
// R6: peripheral mode hides register, test bit set
// R7: write once normal, skip first special
// R8: no-bus-enable bit picks pin 7 use
// R9: test bit never writable normal, pipe wins
// R10: pipe output on pins 6,5 expanded only
// R11: E clock bit write class, E input peripheral
// R12: E output needs stretch bit zero single-chip
// R13: low strobe on pin 3 outside narrow/single; the code also enables it in special narrow and disables it in peripheral
// R14: pin 3 low at E fall tags low byte
// R15: read/write pin 2 outside single-chip; the code also leaves pin 2 GPIO in peripheral
// R16: software enables strobe, rw before writes
// R17: calibration bit anytime, drives pin 7
// R18: select bit chooses bus enable or inverted E
// R19: inverted E is exact complement of E
// R20: pull enables act on input pins only
// R21: control port pull-ups on pins 7,3,2,1,0
// R22: reduced drive per port, write once normal
// R23: interrupt pins never driven, always readable
// R24: drive unused bits zero, once flags per register
module port_e_pin_assignment
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic [2:0]  mode_pins,
    input  wire logic        e_stretch_bit,
    input  wire logic        tag_enable,
    input  wire logic        e_clock,
    input  wire logic        data_bus_enable,
    input  wire logic        pipe_status_hi,
    input  wire logic        pipe_status_lo,
    input  wire logic        clockgen_test,
    input  wire logic        low_byte_strobe,
    input  wire logic        rw_bus,
    input  wire logic        cal_ref,
    input  wire logic [7:0]  ctrl_port_direction,
    input  wire logic [7:0]  gpio_out,
    input  wire logic [7:0]  pin_in,
    output var  logic [7:0]  pin_out,
    output var  logic [7:0]  pin_oe,
    output var  logic [7:0]  pin_pull_en,
    output var  logic [7:0]  gpio_in,
    output var  logic        low_byte_tag,
    output var  logic [5:0]  pull_en_port,
    output var  logic [5:0]  low_drive_port
);
    import port_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    op_mode_e   mode_q;
    logic       boot_q;
    logic [7:0] assign_q, pull_q, drive_q;
    logic       assign_wr_q, drive_wr_q;
    logic [7:0] pin_s1_q, pin_s2_q;
    logic       e_prev_q;

    function automatic logic is_special(input op_mode_e m);
        return m[2] || m == MODE_SPEC_SINGLE;
    endfunction
    function automatic logic is_single(input op_mode_e m);
        return m == MODE_NORM_SINGLE || m == MODE_SPEC_SINGLE;
    endfunction
    function automatic logic [7:0] reset_value(input op_mode_e m);
        case (m)
            MODE_NORM_SINGLE:  return RST_NORM_SC;
            MODE_SPEC_SINGLE:  return RST_SPEC_SC;
            MODE_PERIPHERAL:   return RST_PERIPH;
            MODE_NORM_EXP_NAR,
            MODE_NORM_EXP_WIDE: return RST_NORM_EXP;
            default:           return RST_SPEC_EXP;
        endcase
    endfunction

    wire logic special = (mode_q != MODE_PERIPHERAL) && is_special(mode_q);
    wire logic single  = is_single(mode_q);
    wire logic periph  = mode_q == MODE_PERIPHERAL;
    wire logic narrow_norm = mode_q == MODE_NORM_EXP_NAR;
    wire logic expanded = !single && !periph;

    // Mode strap captured in the first cycle after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_NORM_SINGLE;
            boot_q <= 1'b1;
        end else if (boot_q) begin
            mode_q <= op_mode_e'(mode_pins);
            boot_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    apb_if bus ();
    assign bus.psel    = psel;
    assign bus.penable = penable;
    assign bus.pwrite  = pwrite;
    assign bus.paddr   = paddr;
    assign bus.pwdata  = pwdata;
    assign bus.pstrb   = pstrb;

    apb_slave u_slave (
        .bus     (bus.slave),
        .pready  (pready),
        .pslverr (pslverr),
        .prdata  (prdata)
    );

    // Registers other than the mode register are absent in peripheral mode (see R6) (see R20) (see R22)
    wire logic sel_assign = paddr == ADDR_ASSIGN && !periph;
    wire logic sel_pull   = paddr == ADDR_PULL && !periph;
    wire logic sel_drive  = paddr == ADDR_DRIVE && !periph;
    wire logic sel_mode   = paddr == ADDR_MODE;
    always_comb begin
        bus.hit   = sel_assign || sel_pull || sel_drive || sel_mode;
        bus.rdata = 32'h0000_0000;
        if (sel_assign)
            bus.rdata[7:0] = assign_q;
        else if (sel_pull)
            bus.rdata[7:0] = pull_q;
        else if (sel_drive)
            bus.rdata[7:0] = drive_q & DRIVE_MASK; // see R24
        else if (sel_mode)
            bus.rdata[2:0] = mode_q;
    end

    // ------------------------------------------------------------
    // Write permission
    // ------------------------------------------------------------
    // Once class: special modes refuse the first write, normal modes accept only it
    function automatic logic may_write(input wr_class_e c,
                                       input logic spec,
                                       input logic sc,
                                       input logic done);
        case (c)
            WR_ANY:       return 1'b1;
            WR_ONCE_NORM: return spec ? done : !done; // see R7
            WR_NEVER_N:   return spec && done; // see R9
            WR_ECLK:      return sc && (spec || !done); // see R11
            default:      return 1'b0;
        endcase
    endfunction

    wire logic wr_assign = bus.wr_fire && sel_assign && pstrb[0];
    wire logic wr_pull   = bus.wr_fire && sel_pull && pstrb[0];
    wire logic wr_drive  = bus.wr_fire && sel_drive && pstrb[0];
    logic [7:0] assign_wmask;
    always_comb begin
        assign_wmask = 8'h00;
        for (int i = 0; i < 8; i++) begin
            case (i)
                BIT_CAL_EN:   assign_wmask[i] = 1'b1; // see R17
                BIT_TEST_OUT: assign_wmask[i] =
                    may_write(WR_NEVER_N, special, single, assign_wr_q);
                BIT_NO_ECLK:  assign_wmask[i] =
                    may_write(WR_ECLK, special, single, assign_wr_q);
                default:   assign_wmask[i] =
                    may_write(WR_ONCE_NORM, special, single, assign_wr_q);
            endcase
        end
    end
    wire logic drive_ok =
        may_write(WR_ONCE_NORM, special, single, drive_wr_q); // see R22

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset value loaded in the strap cycle (see R1) (see R2)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            assign_q <= RST_NORM_EXP;
        end else if (boot_q) begin
            assign_q <= reset_value(op_mode_e'(mode_pins)); // see R3 R4 R6
        end else if (wr_assign) begin
            assign_q <= (pwdata[7:0] & assign_wmask) |
                        (assign_q & ~assign_wmask);
        end
    end

    // Once flags per register, cleared by reset only (see R24)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            assign_wr_q <= 1'b0;
            drive_wr_q  <= 1'b0;
        end else begin
            if (wr_assign)
                assign_wr_q <= 1'b1;
            if (wr_drive)
                drive_wr_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pull_q <= RST_PULL;
        else if (wr_pull)
            pull_q <= pwdata[7:0]; // see R20
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            drive_q <= RST_DRIVE;
        else if (wr_drive && drive_ok)
            drive_q <= pwdata[7:0] & DRIVE_MASK; // see R24
    end

    // ------------------------------------------------------------
    // Pin function
    // ------------------------------------------------------------
    wire logic f_bus_en   = expanded && !assign_q[BIT_NO_BUS_EN]; // see R8
    wire logic f_inv_e    = f_bus_en && assign_q[BIT_INV_E_SEL]; // see R18
    wire logic f_cal      = assign_q[BIT_CAL_EN] && // see R17
                            (single || periph || assign_q[BIT_NO_BUS_EN]);
    wire logic f_pipe     = expanded && assign_q[BIT_PIPE_OUT]; // see R10
    wire logic f_test_out = assign_q[BIT_TEST_OUT] && !single &&
                            !(expanded && !special) && !f_pipe; // see R9
    wire logic f_eclk     = !assign_q[BIT_NO_ECLK] &&
                            !(single && e_stretch_bit); // see R12
    wire logic f_strobe   = assign_q[BIT_STROBE_EN] && !single &&
                            !narrow_norm && !periph; // see R13
    wire logic f_rw       = assign_q[BIT_RW_EN] && !single &&
                            !periph; // see R15

    logic [7:0] alt_sel, alt_val;
    always_comb begin
        alt_sel = 8'h00;
        alt_val = 8'h00;
        alt_sel[PIN_BUS_EN] = f_bus_en || f_cal;
        alt_val[PIN_BUS_EN] = f_bus_en ? (f_inv_e ? !e_clock  // see R19
                                                  : data_bus_enable)
                                       : cal_ref;
        alt_sel[PIN_PIPE_H] = f_pipe || f_test_out;
        alt_val[PIN_PIPE_H] = f_pipe ? pipe_status_hi : clockgen_test;
        alt_sel[PIN_PIPE_L] = f_pipe;
        alt_val[PIN_PIPE_L] = pipe_status_lo;
        alt_sel[PIN_ECLK]   = f_eclk;
        alt_val[PIN_ECLK]   = e_clock;
        alt_sel[PIN_STROBE] = f_strobe;
        alt_val[PIN_STROBE] = low_byte_strobe;
        alt_sel[PIN_RW]     = f_rw;
        alt_val[PIN_RW]     = rw_bus;
    end

    // Alternate functions bypass the direction bits (see R5)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 8'h00;
            pin_oe  <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                pin_out[i] <= alt_sel[i] ? alt_val[i] : gpio_out[i];
                pin_oe[i]  <= (alt_sel[i] || ctrl_port_direction[i]) &&
                              !INPUT_ONLY[i]; // see R23
            end
            // E is an input in peripheral mode (see R11)
            if (periph) begin
                pin_oe[PIN_ECLK] <= 1'b0;
            end
        end
    end

    // Pull-ups only on listed pins that are inputs (see R20) (see R21)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_pull_en    <= 8'h00;
            pull_en_port   <= 6'h00;
            low_drive_port <= 6'h00;
        end else begin
            pin_pull_en <= (pull_q[BIT_PULL_CTRL] ? PULL_PINS : 8'h00) &
                           ~pin_oe;
            pull_en_port   <= {pull_q[7:4], pull_q[1:0]};
            low_drive_port <= {drive_q[7:4], drive_q[1:0]}; // see R22
        end
    end

    // ------------------------------------------------------------
    // Input sampling and tag
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
            gpio_in  <= 8'h00;
        end else begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
            gpio_in  <= pin_s2_q; // see R23
        end
    end

    // Tag qualifier on E falling edge (see R14)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            e_prev_q     <= 1'b0;
            low_byte_tag <= 1'b0;
        end else begin
            e_prev_q     <= e_clock;
            low_byte_tag <= e_prev_q && !e_clock && special && expanded &&
                            assign_q[BIT_STROBE_EN] && tag_enable &&
                            !pin_s2_q[PIN_STROBE];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_irq_pins_input: assert property (@(posedge pclk) disable iff (!presetn)
        pin_oe[1:0] == 2'b00) else $error("interrupt pin driven"); // see R23
    a_normal_sc_reset: assert property (@(posedge pclk)
        disable iff (!presetn)
        $fell(boot_q) && mode_q == MODE_NORM_SINGLE |-> assign_q == RST_NORM_SC)
        else $error("bad normal single-chip reset value"); // see R1
    a_spec_sc_reset: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(boot_q) && mode_q == MODE_SPEC_SINGLE |-> assign_q == RST_SPEC_SC)
        else $error("bad special single-chip reset value"); // see R4
    a_test_never_norm: assert property (@(posedge pclk) disable iff (!presetn)
        !boot_q && !special |=> $stable(assign_q[BIT_TEST_OUT]))
        else $error("test bit changed in normal mode"); // see R9
    a_once_normal: assert property (@(posedge pclk) disable iff (!presetn)
        !boot_q && !special && !periph && assign_wr_q
        |=> $stable(assign_q[BIT_NO_BUS_EN]))
        else $error("second write accepted"); // see R7
    a_first_special: assert property (@(posedge pclk) disable iff (!presetn)
        !boot_q && special && !assign_wr_q && wr_assign
        |=> $stable(assign_q[BIT_PIPE_OUT]))
        else $error("first special write accepted"); // see R7
    a_drive_unused: assert property (@(posedge pclk) disable iff (!presetn)
        (drive_q & ~DRIVE_MASK) == 8'h00)
        else $error("unused drive bit set"); // see R24
    a_periph_hidden: assert property (@(posedge pclk) disable iff (!presetn)
        periph && psel && penable && paddr == ADDR_ASSIGN |-> pslverr)
        else $error("register visible in peripheral mode"); // see R6
    a_inv_e_follow: assert property (@(posedge pclk) disable iff (!presetn)
        f_inv_e && !f_cal |=> pin_out[PIN_BUS_EN] == !$past(e_clock))
        else $error("inverted E mismatch"); // see R19
    c_assign_write: cover property (@(posedge pclk) wr_assign);
    c_periph_mode: cover property (@(posedge pclk) periph && !boot_q);
    c_pipe_out: cover property (@(posedge pclk) f_pipe);
    c_tag_seen: cover property (@(posedge pclk) low_byte_tag);
endmodule
`default_nettype wire

// ### verif/tb_port_e_pin_assignment.sv
`timescale 1ns/10ps
`default_nettype none
module tb_port_e_pin_assignment;
    import port_ctrl_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  mode_pins;
    logic        e_stretch_bit;
    logic        tag_enable;
    logic        e_clk;
    logic        bus_en_src;
    logic        strobe_src;
    logic [7:0]  gpio_drv;
    logic [7:0]  dir;
    logic [7:0]  pin_in;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic [7:0]  pin_pull_en;
    logic [7:0]  gpio_in;
    logic        low_byte_tag;
    logic [5:0]  pull_en_port;
    logic [5:0]  low_drive_port;
    int          n_errors;
    int          check_count;

    port_e_pin_assignment dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode_pins(mode_pins), .e_stretch_bit(e_stretch_bit),
        .tag_enable(tag_enable), .e_clock(e_clk),
        .data_bus_enable(bus_en_src),
        .pipe_status_hi(1'b0), .pipe_status_lo(1'b1),
        .clockgen_test(1'b1), .low_byte_strobe(strobe_src), .rw_bus(1'b1),
        .cal_ref(1'b1), .ctrl_port_direction(dir), .gpio_out(gpio_drv),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull_en(pin_pull_en), .gpio_in(gpio_in),
        .low_byte_tag(low_byte_tag), .pull_en_port(pull_en_port),
        .low_drive_port(low_drive_port)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic do_reset(input op_mode_e m);
        @(posedge pclk);
        presetn   <= 1'b0;
        mode_pins <= m;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    // Holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [7:0] exp,
                       input logic exp_err, input string nm);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 8'h00, rd, err);
        chk({nm, "_err"}, {31'h0, err}, {31'h0, exp_err});
        if (!exp_err) begin
            chk(nm, rd, {24'h000000, exp});
        end
    endtask

    // Pin outputs lag their sources by one cycle, gpio_in lags pin_in by three
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        op_mode_e   md [5];
        logic [7:0] rv [5];
        logic [7:0] oe [5];
        md = '{MODE_NORM_SINGLE, MODE_NORM_EXP_NAR, MODE_NORM_EXP_WIDE,
               MODE_SPEC_SINGLE, MODE_SPEC_EXP_WIDE};
        rv = '{8'h90, 8'h00, 8'h00, 8'h2E, 8'h2C};
        oe = '{8'h00, 8'h90, 8'h90, 8'h90, 8'hFC};
        dir <= 8'h00;
        for (int i = 0; i < 5; i++) begin
            do_reset(md[i]);
            rdc(ADDR_ASSIGN, rv[i], 1'b0, "assign_rst");
            rdc(ADDR_PULL, 8'h00, 1'b0, "pull_rst");
            rdc(ADDR_DRIVE, 8'h00, 1'b0, "drive_rst");
            settle();
            chk("oe_rst", {24'h0, pin_oe}, {24'h0, oe[i]});
        end
        do_reset(MODE_PERIPHERAL);
        rdc(ADDR_ASSIGN, 8'h00, 1'b1, "assign_hidden");
        rdc(ADDR_PULL, 8'h00, 1'b1, "pull_hidden");
        rdc(ADDR_DRIVE, 8'h00, 1'b1, "drive_hidden");
        settle();
        chk("pin6_test", {30'h0, pin_oe[6], pin_out[6]}, 32'h3);
        $display("test reset_values done");
    endtask

    task automatic t_write_once();
        for (int i = 0; i < 2; i++) begin
            do_reset(i == 0 ? MODE_NORM_EXP_WIDE : MODE_NORM_EXP_NAR);
            wr(ADDR_ASSIGN, 8'h5C);
            rdc(ADDR_ASSIGN, 8'h0C, 1'b0, "once_first");
            wr(ADDR_ASSIGN, 8'h00);
            rdc(ADDR_ASSIGN, 8'h0C, 1'b0, "once_second");
            wr(ADDR_ASSIGN, 8'h0E);
            rdc(ADDR_ASSIGN, 8'h0E, 1'b0, "cal_any");
            settle();
            chk("strobe_oe", {30'h0, pin_oe[3:2]},
                i == 0 ? 32'h3 : 32'h1);
            chk("rw_pin", {31'h0, pin_out[2]}, 32'h1);
            chk("strobe_out", {31'h0, pin_out[3]},
                i == 0 ? 32'h1 : 32'h0);
        end
        $display("test write_once done");
    endtask

    task automatic t_special_pins();
        do_reset(MODE_SPEC_EXP_WIDE);
        settle();
        chk("bus_en_pin", {30'h0, pin_oe[7], pin_out[7]}, 32'h3);
        chk("pipe_pins", {30'h0, pin_out[6:5]}, 32'h1);
        wr(ADDR_ASSIGN, 8'h00);
        rdc(ADDR_ASSIGN, 8'h2C, 1'b0, "spec_first");
        wr(ADDR_ASSIGN, 8'h01);
        rdc(ADDR_ASSIGN, 8'h01, 1'b0, "spec_later");
        settle();
        chk("inv_e", {30'h0, pin_oe[7], pin_out[7]}, 32'h2);
        chk("gpio_oe", {24'h0, pin_oe}, 32'h90);
        wr(ADDR_ASSIGN, 8'hC2);
        settle();
        chk("cal_pin", {30'h0, pin_oe[7], pin_out[7]}, 32'h3);
        chk("test_pin", {31'h0, pin_out[6]}, 32'h1);
        wr(ADDR_ASSIGN, 8'h62);
        settle();
        chk("pipe_wins", {31'h0, pin_out[6]}, 32'h0);
        do_reset(MODE_SPEC_SINGLE);
        settle();
        chk("e_out", {30'h0, pin_oe[4], pin_out[4]}, 32'h3);
        @(posedge pclk);
        e_stretch_bit <= 1'b1;
        settle();
        chk("e_stretch", {31'h0, pin_oe[4]}, 32'h0);
        @(posedge pclk);
        e_stretch_bit <= 1'b0;
        $display("test special_pins done");
    endtask

    task automatic t_pull_drive();
        do_reset(MODE_NORM_SINGLE);
        wr(ADDR_DRIVE, 8'hFF);
        rdc(ADDR_DRIVE, 8'hF3, 1'b0, "drive_mask");
        wr(ADDR_DRIVE, 8'h00);
        rdc(ADDR_DRIVE, 8'hF3, 1'b0, "drive_once");
        wr(ADDR_PULL, 8'h10);
        rdc(ADDR_PULL, 8'h10, 1'b0, "pull_rw");
        rdc(12'h004, 8'h00, 1'b1, "unmapped");
        dir <= 8'h0C;
        settle();
        chk("low_drive", {26'h0, low_drive_port}, 32'h3F);
        chk("pull_port", {26'h0, pull_en_port}, 32'h04);
        chk("pull_pins", {24'h0, pin_pull_en}, 32'h83);
        @(posedge pclk);
        dir <= 8'hFF;
        gpio_drv <= 8'h5A;
        pin_in <= 8'hA5;
        settle();
        chk("irq_oe", {30'h0, pin_oe[1:0]}, 32'h0);
        chk("gpio_out", {24'h0, pin_out}, 32'h5A);
        chk("irq_pull", {24'h0, pin_pull_en}, 32'h03);
        chk("gpio_in", {24'h0, gpio_in}, 32'hA5);
        $display("test pull_drive done");
    endtask

    // Tag needs a falling E with pin 3 low; a high pin must not tag
    task automatic t_tag();
        do_reset(MODE_SPEC_EXP_WIDE);
        tag_enable <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            pin_in <= i == 0 ? 8'h00 : 8'h08;
            e_clk  <= 1'b1;
            settle();
            @(posedge pclk);
            e_clk <= 1'b0;
            @(posedge pclk);
            #1;
            chk("low_tag", {31'h0, low_byte_tag},
                i == 0 ? 32'h1 : 32'h0);
            @(posedge pclk);
        end
        tag_enable <= 1'b0;
        e_clk      <= 1'b1;
        $display("test tag done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        n_errors = 0;
        check_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        mode_pins = 3'h0;
        e_stretch_bit = 1'b0;
        tag_enable = 1'b0;
        e_clk = 1'b1;
        bus_en_src = 1'b1;
        strobe_src = 1'b1;
        gpio_drv = 8'h00;
        dir = 8'h00;
        pin_in = 8'h00;
        t_reset_values();
        t_write_once();
        t_special_pins();
        t_pull_drive();
        t_tag();
        end_of_test();
    end
endmodule
`default_nettype wire
